// >>> src/sacs_params.svh
// Function
// - Eight or four inputs; mux picks one.
// - Software picks internal or serial-derived conversion clock.
// - Internal clock: sample 3, convert 18 cycles.
// - Serial source: toggle on each rising edge.
// - Serial source: convert starts on later rising edge.
// - Auto scan ascends, wraps back to manual channel.
// - Auto scan needs no channel write.
// - Clearing bit 11 stops the scan.
// - Sample and convert on convert-start falling edge.
// - Completion to next fall is acquisition.
// - Manual trigger starts only from the pin.
// - Bit 9 low selects auto-trigger.
// - Auto-trigger at fast rate: restart 3 cycles after completion.
// - Slow rate gives 42-cycle frames.
// - Bit 6 picks pin function, bit 7 polarity.
`ifndef SACS_PARAMS_SVH
`define SACS_PARAMS_SVH

`define SACS_CLK_PERIOD_PS    4000

`define SACS_CFG_OFFSET       8'h00
`define SACS_CMD_OFFSET       8'h04
`define SACS_STAT_OFFSET      8'h08

`define SACS_CFG_RESET        12'h240
`define SACS_CMD_RESET        3'h0

`define SACS_CFG_AUTO_SEL     11
`define SACS_CFG_SRC_SCLK     10
`define SACS_CFG_MAN_TRIG     9
`define SACS_CFG_SLOW_RATE    8
`define SACS_CFG_POL_HIGH     7
`define SACS_CFG_PIN_EOC      6

`define SACS_STAT_SHORT_BIT   7

`define SACS_SAMPLE_TICKS     3
`define SACS_CONV_TICKS       18
`define SACS_FRAME_FAST_TICKS 21
`define SACS_FRAME_SLOW_TICKS 42

`define SACS_CONVST_LOW_NS    120
`define SACS_CONVST_LOW_CYC   ((`SACS_CONVST_LOW_NS * 1000 + \
  `SACS_CLK_PERIOD_PS - 1) / `SACS_CLK_PERIOD_PS)

`define SACS_INT_DIV          12

`endif

// >>> src/sacs_pkg.sv
package sacs_pkg;

  typedef enum logic [1:0] {
    SACS_IDLE = 2'b00,
    SACS_ARM  = 2'b01,
    SACS_CONV = 2'b11,
    SACS_ACQ  = 2'b10
  } sacs_state_type;

  typedef logic [2:0] sacs_chan_type;

endpackage

// >>> src/sacs_conversion_clock_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "sacs_params.svh"

module sacs_convclk_gen #(
  parameter int INT_DIV = `SACS_INT_DIV
) (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  // Source select and serial clock pin
  input  wire logic src_sclk_i,
  input  wire logic sclk_i,
  // Conversion clock strobe
  output logic      tick_o
);

  localparam int DW = $clog2(INT_DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(INT_DIV - 1);

  logic          sclk_s1;
  logic          sclk_s2;
  logic          sclk_s3;
  logic          conv_clk_level;
  logic [DW-1:0] div_cnt;

  wire logic sclk_rise = sclk_s2 & ~sclk_s3;
  wire logic int_tick  = (div_cnt == DIV_LAST);
  wire logic sclk_tick = sclk_rise & ~conv_clk_level;

  // The internal oscillator is modelled as a divider of the system clock.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || int_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DW'(1);
    end
  end

  // Two stages before the edge detector; only the second is looked at.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
    end else begin
      sclk_s1 <= sclk_i;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
    end
  end

  // Halving: the conversion clock flips on every serial rising edge.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      conv_clk_level <= 1'b0;
    end else if (sclk_rise) begin
      conv_clk_level <= ~conv_clk_level;
    end
  end

  // One strobe per conversion clock period from the chosen source.
  assign tick_o = src_sclk_i ? sclk_tick : int_tick;

endmodule
`default_nettype wire

// >>> src/sacs_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "sacs_params.svh"

module sacs_sequencer #(
  parameter int NUM_CH  = 8,
  parameter int INT_DIV = `SACS_INT_DIV
) (
  // Clock and reset
  input  wire logic                   ref_clk_i,
  input  wire logic                   reset_i,
  // APB slave
  input  wire logic                   psel_i,
  input  wire logic                   penable_i,
  input  wire logic                   pwrite_i,
  input  wire logic [7:0]             paddr_i,
  input  wire logic [31:0]            pwdata_i,
  output logic      [31:0]            prdata_o,
  output logic                        pready_o,
  output logic                        pslverr_o,
  // Pins from the host
  input  wire logic                   sclk_i,
  input  wire logic                   convert_start_n_i,
  // Converter core control
  output sacs_pkg::sacs_chan_type     mux_channel_o,
  output logic                        sample_o,
  output logic                        converting_o,
  output logic                        conv_done_o,
  // Status pin
  output logic                        status_pin_o
);

  import sacs_pkg::*;

  localparam logic [5:0] CONV_LAST = 6'(`SACS_CONV_TICKS - 1);
  localparam logic [5:0] ACQ_MIN   = 6'(`SACS_SAMPLE_TICKS - 1);
  localparam logic [5:0] GAP_FAST  =
    6'(`SACS_FRAME_FAST_TICKS - `SACS_CONV_TICKS - 1);
  localparam logic [5:0] GAP_SLOW  =
    6'(`SACS_FRAME_SLOW_TICKS - `SACS_CONV_TICKS - 1);
  localparam logic [4:0] LOW_MIN   = 5'(`SACS_CONVST_LOW_CYC);
  localparam sacs_chan_type LAST_CH = 3'(NUM_CH - 1);

  function automatic sacs_chan_type next_scan(input sacs_chan_type ch,
                                              input sacs_chan_type start);
    next_scan = (ch >= LAST_CH) ? start : ch + 3'h1;
  endfunction

  logic [11:0]    cfg;
  sacs_chan_type  man_ch;
  sacs_chan_type  cur_ch;
  sacs_state_type state;
  sacs_state_type next_state;
  logic [5:0]     cnt;
  logic [5:0]     next_cnt;
  logic           cs_s1;
  logic           cs_s2;
  logic           cs_s3;
  logic [4:0]     low_cnt;
  logic           irq_pend;
  logic           short_flag;
  logic           tick;

  sacs_convclk_gen #(
    .INT_DIV (INT_DIV)
  ) u_convclk (
    .ref_clk_i  (ref_clk_i),
    .reset_i    (reset_i),
    .src_sclk_i (cfg[`SACS_CFG_SRC_SCLK]),
    .sclk_i     (sclk_i),
    .tick_o     (tick)
  );

  // Configuration decode.
  wire logic auto_sel  = cfg[`SACS_CFG_AUTO_SEL];
  wire logic src_sclk  = cfg[`SACS_CFG_SRC_SCLK];
  wire logic auto_trig = ~cfg[`SACS_CFG_MAN_TRIG];
  wire logic slow_rate = cfg[`SACS_CFG_SLOW_RATE];
  wire logic pol_high  = cfg[`SACS_CFG_POL_HIGH];
  wire logic pin_eoc   = cfg[`SACS_CFG_PIN_EOC];

  // APB decode; the slave never inserts wait states.
  wire logic setup   = psel_i & ~penable_i;
  wire logic access  = psel_i & penable_i;
  wire logic hit_cfg = (paddr_i == `SACS_CFG_OFFSET);
  wire logic hit_cmd = (paddr_i == `SACS_CMD_OFFSET);
  wire logic hit_st  = (paddr_i == `SACS_STAT_OFFSET);
  wire logic addr_ok = hit_cfg | hit_cmd | hit_st;
  wire logic wr_cfg  = access & pwrite_i & hit_cfg;
  wire logic wr_cmd  = access & pwrite_i & hit_cmd;
  wire logic wr_st   = access & pwrite_i & hit_st;
  wire logic rd_st   = access & ~pwrite_i & hit_st;

  // Channel numbers beyond the fitted inputs are refused.
  wire logic ch_ok   = ({29'h0, pwdata_i[2:0]} <= 32'(LAST_CH)) &&
                       (pwdata_i[31:3] == 29'h0);

  wire logic [31:0] stat_word = {24'h0, short_flag, irq_pend,
                                 converting_o, cur_ch, state};
  wire logic [31:0] rd_value  =
    hit_cfg ? {20'h0, cfg} :
    hit_cmd ? {29'h0, man_ch} :
    hit_st  ? stat_word : 32'h0;

  // Pin events, seen only after two synchroniser stages.
  wire logic trig_fall = cs_s3 & ~cs_s2;
  wire logic trig_rise = ~cs_s3 & cs_s2;

  // Sequencer decode.
  wire logic [5:0] gap_last = slow_rate ? GAP_SLOW : GAP_FAST;
  wire logic [5:0] acq_last = auto_trig ? gap_last : ACQ_MIN;
  wire logic conv_done  = (state == SACS_CONV) && tick && (cnt == CONV_LAST);
  wire logic acq_over   = (state == SACS_ACQ) && tick && (cnt >= acq_last);
  // Manual starts come only from the pin; auto starts end the gap.
  wire logic man_start  = (state == SACS_IDLE) && ~auto_trig &&
                          trig_fall;
  wire logic start_samp = man_start | (acq_over & auto_trig);
  wire logic eoc_active = (state == SACS_ARM) || (state == SACS_CONV);
  wire logic pin_active = pin_eoc ? eoc_active : irq_pend;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      SACS_IDLE: begin
        if (auto_trig) begin
          next_state = SACS_ACQ;
          next_cnt   = 6'h00;
        end else if (man_start) begin
          // The serial source waits for its next conversion edge.
          next_state = src_sclk ? SACS_ARM : SACS_CONV;
          next_cnt   = 6'h00;
        end
      end
      SACS_ARM: begin
        if (tick) begin
          next_state = SACS_CONV;
        end
      end
      SACS_CONV: begin
        // Pin edges are not looked at here, so they are dropped.
        if (tick) begin
          if (cnt == CONV_LAST) begin
            next_state = SACS_ACQ;
            next_cnt   = 6'h00;
          end else begin
            next_cnt = cnt + 6'h01;
          end
        end
      end
      SACS_ACQ: begin
        // From completion, acquisition runs to the next start in auto mode and for three clocks, then idle, in manual mode.
        if (acq_over) begin
          next_state = auto_trig ? SACS_CONV : SACS_IDLE;
          next_cnt   = 6'h00;
        end else if (tick) begin
          next_cnt = cnt + 6'h01;
        end
      end
      default: begin
        next_state = SACS_IDLE;
        next_cnt   = 6'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state <= SACS_IDLE;
      cnt   <= 6'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= convert_start_n_i;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // Low-time check on the pin; a short pulse still triggers but is flagged.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || cs_s2) begin
      low_cnt <= 5'h00;
    end else if (low_cnt != LOW_MIN) begin
      low_cnt <= low_cnt + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      short_flag <= 1'b0;
    end else if (trig_rise && (low_cnt < LOW_MIN)) begin
      short_flag <= 1'b1;
    end else if (wr_st && pwdata_i[`SACS_STAT_SHORT_BIT]) begin
      short_flag <= 1'b0;
    end
  end

  // Interrupt mode: set at completion, dropped by a status read.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_pend <= 1'b0;
    end else if (conv_done) begin
      irq_pend <= 1'b1;
    end else if (rd_st) begin
      irq_pend <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg <= `SACS_CFG_RESET;
    end else if (wr_cfg) begin
      cfg <= pwdata_i[11:0];
    end
  end

  // Command writes only steer the channel while manual select holds.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      man_ch <= `SACS_CMD_RESET;
    end else if (wr_cmd && ch_ok && !auto_sel) begin
      man_ch <= pwdata_i[2:0];
    end
  end

  // The scan starts from the manual channel and steps after each result.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cur_ch <= `SACS_CMD_RESET;
    end else if (!auto_sel) begin
      cur_ch <= man_ch;
    end else if (conv_done) begin
      cur_ch <= next_scan(cur_ch, man_ch);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      sample_o     <= 1'b0;
      converting_o <= 1'b0;
      conv_done_o  <= 1'b0;
      status_pin_o <= 1'b1;
    end else begin
      sample_o     <= start_samp;
      converting_o <= (next_state == SACS_CONV);
      conv_done_o  <= conv_done;
      status_pin_o <= pol_high ? pin_active : ~pin_active;
    end
  end

  // Read data is caught in the setup cycle, so it is valid all access long.
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end else if (setup) begin
      prdata_o  <= pwrite_i ? 32'h0 : rd_value;
      pslverr_o <= ~addr_ok;
    end
  end

  assign pready_o      = 1'b1;
  assign mux_channel_o = cur_ch;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence idle_fall_s;
    (state == SACS_IDLE) && !auto_trig && trig_fall && !src_sclk;
  endsequence

  sequence conv_begin_s;
    sample_o && (state == SACS_CONV);
  endsequence

  conv_len_a:
    assert property (conv_done |=> (state == SACS_ACQ) && conv_done_o)
    else $error("conversion did not end after eighteen clocks");

  conv_hold_a:
    assert property ((state == SACS_CONV) && !conv_done |=>
                     (state == SACS_CONV))
    else $error("conversion left early or was restarted");

  manual_only_a:
    assert property ((state == SACS_IDLE) && !auto_trig && !trig_fall |=>
                     (state == SACS_IDLE) && !sample_o)
    else $error("manual mode started without the pin");

  sclk_arm_a:
    assert property ((state == SACS_ARM) && !tick |=> (state == SACS_ARM))
    else $error("serial-clocked start did not wait for its edge");

  sample_edge_a:
    assert property (idle_fall_s |=> conv_begin_s)
    else $error("falling pin edge did not sample and convert");

  auto_enter_a:
    assert property ((state == SACS_IDLE) && auto_trig |=>
                     (state == SACS_ACQ))
    else $error("auto trigger did not start its frame");

  auto_fast_a:
    assert property ((state == SACS_ACQ) && tick && auto_trig &&
                     !slow_rate && (cnt == 6'd2) |=> conv_begin_s)
    else $error("fast frame did not restart after three clocks");

  auto_slow_a:
    assert property ((state == SACS_ACQ) && tick && auto_trig &&
                     slow_rate && (cnt == 6'd22) |=> (state == SACS_ACQ))
    else $error("slow frame restarted too early");

  scan_wrap_a:
    assert property (conv_done && auto_sel && (cur_ch == LAST_CH) |=>
                     (cur_ch == $past(man_ch)))
    else $error("scan did not wrap to the start channel");

  scan_step_a:
    assert property (conv_done && auto_sel && (cur_ch < LAST_CH) |=>
                     (cur_ch == $past(cur_ch) + 3'h1))
    else $error("scan did not advance after a conversion");

  scan_stop_a:
    assert property (!auto_sel |=> (cur_ch == $past(man_ch)))
    else $error("scan continued with auto select cleared");

  pin_pol_a:
    assert property (pin_eoc && (state == SACS_CONV) |=>
                     (status_pin_o == $past(pol_high)))
    else $error("status pin shows the wrong level while converting");

endmodule
`default_nettype wire

// >>> test/sacs_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module sacs_host_model (
  // Bench control
  input  wire logic       ref_clk_i,
  input  wire logic       sclk_run_i,
  input  wire logic       fire_i,
  input  wire logic [7:0] low_cyc_i,
  // Pins into the device
  output logic            sclk_o,
  output logic            convert_start_n_o
);
  logic [7:0] low_cnt = 8'h00;
  logic [2:0] div     = 3'h0;
  logic       sclk_q  = 1'b0;
  logic       cs_q    = 1'b1;

  assign sclk_o            = sclk_q;
  assign convert_start_n_o = cs_q;

  // The serial clock stands low between frames, as a real host's would.
  always @(posedge ref_clk_i) begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    if (div == 3'h4)
      sclk_q <= sclk_run_i ? ~sclk_q : 1'b0;
  end

  // One fire request gives one low pulse of the requested width.
  always @(posedge ref_clk_i) begin
    if (fire_i) begin
      cs_q <= 1'b0;
      low_cnt <= low_cyc_i;
    end else if (low_cnt != 8'h00) begin
      low_cnt <= low_cnt - 8'h01;
    end else begin
      cs_q <= 1'b1;
    end
  end
endmodule

`default_nettype wire

// >>> test/sacs_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none

module sacs_sequencer_tb;
  import sacs_pkg::*;
  typedef struct {logic w; logic [31:0] d; logic [31:0] m; logic e;}
    sacs_apb_type;
  typedef struct {sacs_chan_type ch; int lo; int hi; logic pin; int gap;}
    sacs_conv_type;
  localparam int D = 2;
  localparam int P = 20;
  logic          clk, rst, psel, penable, pwrite, sclk_run, fire_r;
  logic          sclk, cs_n, pready, pslverr, sample, conv, done, spin;
  logic [7:0]    paddr, low_cyc;
  logic [31:0]   pwdata, prdata;
  sacs_chan_type mux_ch, cur_ch;
  sacs_apb_type  rq[$];
  sacs_conv_type cq[$];
  sacs_apb_type  na;
  sacs_conv_type nc;
  int            n_fail, n_compared, n_done, len, cyc, t_smp, t_prev;
  integer        seed = 32'heae8cde4;

  sacs_sequencer #(.NUM_CH(8), .INT_DIV(D)) u_dut (
    .ref_clk_i(clk), .reset_i(rst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .sclk_i(sclk), .convert_start_n_i(cs_n), .mux_channel_o(mux_ch),
    .sample_o(sample), .converting_o(conv), .conv_done_o(done),
    .status_pin_o(spin));

  sacs_host_model u_host (
    .ref_clk_i(clk), .sclk_run_i(sclk_run), .fire_i(fire_r),
    .low_cyc_i(low_cyc), .sclk_o(sclk), .convert_start_n_o(cs_n));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The note is queued first; the monitor checks it at the access edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    rq.push_back('{w, d, m, e});
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic fire(input logic [7:0] lw);
    @(posedge clk);
    fire_r <= 1'b1;
    low_cyc <= lw;
    @(posedge clk);
    fire_r <= 1'b0;
  endtask

  task automatic man(input sacs_chan_type ch, input logic pin, input int p,
                     input logic [7:0] lw, input logic twice);
    apb(1'b1, 8'h04, {29'h0, ch}, 32'h0, 1'b0);
    cq.push_back('{ch, 17 * p + 1, 18 * p + 1, pin, 0});
    fire(twice ? 8'h1e : lw);
    if (twice) begin
      // A fresh fall while the first conversion still runs.
      @(posedge cs_n);
      fire(8'h28);
    end
    repeat (26 * p) @(posedge clk);
  endtask

  task automatic auto(input logic [11:0] cf, input int n, input int g,
                      input logic scan);
    int k;
    k = n_done + n;
    for (int i = 0; i < n; i++)
      cq.push_back('{scan ? 3'(5 + i % 3) : 3'h5, 18 * D, 18 * D + 1,
                    1'b0, (i > 0) ? g : 0});
    apb(1'b1, 8'h00, {20'h0, cf}, 32'h0, 1'b0);
    if (scan)
      apb(1'b1, 8'h04, 32'h2, 32'h0, 1'b0);
    if (scan)
      apb(1'b0, 8'h04, 32'h5, 32'h7, 1'b0);
    wait (n_done == k);
    apb(1'b1, 8'h00, 32'h240, 32'h0, 1'b0);
    repeat (60) @(posedge clk);
  endtask

  always @(posedge clk)
    if (psel && penable && pready === 1'b1) begin
      na = rq.pop_front();
      if (!na.w)
        chk("prdata", na.d & na.m, prdata & na.m);
      chk("pslverr", {31'h0, na.e}, {31'h0, pslverr});
    end

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      n_fail++;
      results();
    end
    if (sample === 1'b1) begin
      cur_ch = mux_ch;
      len = 0;
      t_prev = t_smp;
      t_smp = cyc;
    end
    if (conv === 1'b1)
      len++;
    if (conv === 1'b1 && len == 4 && cq.size() > 0)
      chk("status_pin", {31'h0, cq[0].pin}, {31'h0, spin});
    if (done === 1'b1) begin
      n_done++;
      if (cq.size() == 0) begin
        chk("extra_conversion", 32'h0, 32'h1);
      end else begin
        nc = cq.pop_front();
        chk("channel", {29'h0, nc.ch}, {29'h0, cur_ch});
        chk("conv_len", 32'h1,
            {31'h0, len >= nc.lo && len <= nc.hi});
        if (nc.gap != 0)
          chk("frame_cycles", nc.gap, t_smp - t_prev);
      end
    end
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sclk_run = 1'b0;
    fire_r = 1'b0;
    low_cyc = 8'h28;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h240, 32'hfff, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h7, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h3f, 1'b0);
    apb(1'b0, 8'h0c, 32'h0, 32'hffffffff, 1'b1);
    apb(1'b1, 8'h0c, 32'h1, 32'h0, 1'b1);
    $display("test registers done");
    for (int i = 0; i < 4; i++)
      man(3'($random(seed)), 1'b0, D, 8'h1e + 8'({$random(seed)} % 20),
          i == 1);
    apb(1'b1, 8'h00, 32'h2c0, 32'h0, 1'b0);
    man(3'h6, 1'b1, D, 8'h28, 1'b0);
    apb(1'b1, 8'h00, 32'h240, 32'h0, 1'b0);
    man(3'h2, 1'b0, D, 8'h08, 1'b0);
    apb(1'b0, 8'h08, 32'h80, 32'h80, 1'b0);
    apb(1'b1, 8'h08, 32'h80, 32'h0, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h80, 1'b0);
    $display("test manual trigger done");
    sclk_run <= 1'b1;
    apb(1'b1, 8'h00, 32'h640, 32'h0, 1'b0);
    man(3'h4, 1'b0, P, 8'h28, 1'b0);
    apb(1'b1, 8'h00, 32'h240, 32'h0, 1'b0);
    sclk_run <= 1'b0;
    $display("test serial clock done");
    apb(1'b1, 8'h04, 32'h5, 32'h0, 1'b0);
    auto(12'h140, 3, 42 * D, 1'b0);
    auto(12'h840, 4, 21 * D, 1'b1);
    $display("test auto trigger done");
    apb(1'b1, 8'h00, 32'h6c0, 32'h0, 1'b0);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("reset_pins", 32'ha, {28'h0, spin, conv, pready, done});
    chk("reset_data", 32'h0, prdata | {29'h0, mux_ch});
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h240, 32'hfff, 1'b0);
    apb(1'b0, 8'h04, 32'h0, 32'h7, 1'b0);
    apb(1'b1, 8'h00, 32'h200, 32'h0, 1'b0);
    man(3'h1, 1'b1, D, 8'h28, 1'b0);
    chk("irq_pin", 32'h0, {31'h0, spin});
    apb(1'b0, 8'h08, 32'h40, 32'h40, 1'b0);
    apb(1'b0, 8'h08, 32'h0, 32'h40, 1'b0);
    chk("irq_pin", 32'h1, {31'h0, spin});
    $display("test reset and interrupt done");
    chk("pending_notes", 32'h0, cq.size());
    results();
  end
endmodule

`default_nettype wire
